// ---- src/ajb_pkg.sv ----
package ajb_pkg;

  // opcode patterns
  localparam logic [4:0] OPC_JMP_LOW  = 5'h01;
  localparam logic [4:0] OPC_AND_REG  = 5'h0B;
  localparam logic [7:0] OPC_AND_DIR  = 8'h55;
  localparam logic [7:0] OPC_AND_IND0 = 8'h56;
  localparam logic [7:0] OPC_AND_IND1 = 8'h57;
  localparam logic [7:0] OPC_AND_IMM  = 8'h54;
  localparam logic [7:0] OPC_DIR_ACC  = 8'h52;
  localparam logic [7:0] OPC_DIR_IMM  = 8'h53;

  // clocks per machine cycle and reset values
  localparam int          MC_CLKS = 12;
  localparam logic [3:0]  DIV_TOP = 4'(MC_CLKS - 1);
  localparam logic [15:0] PC_RST  = 16'h0000;

  typedef enum logic [2:0] {
    K_NONE  = 3'h0,
    K_JMP   = 3'h1,
    K_A_REG = 3'h2,
    K_A_DIR = 3'h3,
    K_A_IND = 3'h4,
    K_A_IMM = 3'h5,
    K_D_ACC = 3'h6,
    K_D_IMM = 3'h7
  } ajb_kind_t;

  typedef struct packed {
    ajb_kind_t  kind;
    logic [1:0] len;
    logic [1:0] cyc;
  } ajb_dec_t;

  typedef enum logic [7:0] {
    S_OP    = 8'h01,
    S_B2    = 8'h02,
    S_B3    = 8'h04,
    S_ISSUE = 8'h08,
    S_PTR   = 8'h10,
    S_RD    = 8'h20,
    S_EXEC  = 8'h40,
    S_WAIT  = 8'h80
  } ajb_state_t;

  typedef struct packed {
    ajb_state_t  state;
    logic [15:0] pc;
    logic [7:0]  op;
    logic [7:0]  b2;
    logic [7:0]  b3;
    ajb_dec_t    dec;
    logic [7:0]  opnd;
    logic [7:0]  mask;
    logic [1:0]  mc_cnt;
    logic [3:0]  div;
    logic        code_take;
    logic        rd_req;
    logic [7:0]  rd_addr;
    logic        rd_latch;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        acc_we;
    logic [7:0]  acc_wd;
    logic        done;
    logic        bad;
  } ajb_st_t;

  localparam ajb_st_t AJB_RST = '{state: S_OP, pc: PC_RST, dec: '{K_NONE, 2'h0, 2'h0},
                                  default: '0};

endpackage

// ---- src/ajb_decode.sv ----
`timescale 1ns/1ns
module ajb_decode
  import ajb_pkg::*;
(
  input  wire logic [7:0] op,
  output ajb_dec_t        dec
);

  // opcode to kind, length in bytes, machine cycles
  always_comb begin
    dec = '{K_NONE, 2'h1, 2'h1};
    if (op[4:0] == OPC_JMP_LOW) begin
      dec = '{K_JMP, 2'h2, 2'h2};
    end else if (op[7:3] == OPC_AND_REG) begin
      dec = '{K_A_REG, 2'h1, 2'h1};
    end else begin
      unique case (op)
        OPC_AND_DIR: dec = '{K_A_DIR, 2'h2, 2'h1};
        OPC_AND_IND0, OPC_AND_IND1: dec = '{K_A_IND, 2'h1, 2'h1};
        OPC_AND_IMM: dec = '{K_A_IMM, 2'h2, 2'h1};
        OPC_DIR_ACC: dec = '{K_D_ACC, 2'h2, 2'h1};
        OPC_DIR_IMM: dec = '{K_D_IMM, 2'h3, 2'h2};
        default: dec = '{K_NONE, 2'h1, 2'h1};
      endcase
    end
  end

endmodule // ajb_decode

// ---- src/ajb_exec.sv ----
// Operation
// - jump: pc plus two, low eleven bits from opcode 7-5 and byte two
// - jump opcode low five bits 00001; two bytes, two machine cycles
// - byte and writes operand conjunction to destination; flags untouched
// - six forms: acc with reg, direct, indirect, immediate; direct with acc, immediate
// - direct destination reads port output latch, not pins
// - 0101 1rrr: acc and working register; one byte, one cycle
// - 0101 0101 direct: acc and direct byte; two bytes, one cycle
// - 0101 011i: acc and byte at pointer register; one byte, one cycle
// - 0101 0100 imm: acc and constant; two bytes, one cycle
// - 0101 0010 direct: direct and acc back to direct; two bytes, one cycle
// - direct destination clears bit pattern, mask from constant or acc
// - 0101 0011 direct imm: direct and constant; three bytes, two cycles
`timescale 1ns/1ns
module ajb_exec
  import ajb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        code_valid,
  input  wire logic [7:0]  code_byte,
  output logic             code_take,
  output logic [15:0]      program_counter,
  input  wire logic [1:0]  bank_sel,
  input  wire logic [7:0]  acc_value,
  output logic             rd_req,
  output logic [7:0]       rd_addr,
  output logic             rd_latch,
  input  wire logic        rd_valid,
  input  wire logic [7:0]  rd_data,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic             acc_we,
  output logic [7:0]       acc_wd,
  output logic             instr_done,
  output logic             bad_opcode
);

  logic [1:0] rst_sync_q;
  logic       rst_int_n;
  ajb_st_t    q;
  ajb_st_t    d;
  ajb_dec_t   dec;
  logic       tick;
  logic       dir_dest;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  ajb_decode u_dec (
    .op  (code_byte),
    .dec (dec)
  );

  assign tick     = (q.div == DIV_TOP);
  assign dir_dest = (q.dec.kind == K_D_ACC) || (q.dec.kind == K_D_IMM);

  // next state of the whole block
  always_comb begin
    d           = q;
    d.code_take = 1'b0;
    d.rd_req    = 1'b0;
    d.wr_en     = 1'b0;
    d.acc_we    = 1'b0;
    d.done      = 1'b0;
    d.bad       = 1'b0;
    d.div       = tick ? 4'h0 : q.div + 4'h1;
    if (tick && q.mc_cnt != 2'h3) begin
      d.mc_cnt = q.mc_cnt + 2'h1;
    end
    unique case (q.state)
      S_OP: begin
        if (code_valid && !q.code_take) begin
          d.code_take = 1'b1;
          d.op        = code_byte;
          d.dec       = dec;
          d.pc        = q.pc + 16'h1;
          d.mc_cnt    = 2'h0;
          d.div       = 4'h0;
          if (dec.kind == K_NONE) begin
            d.bad = 1'b1; // not handled here, skipped
          end else if (dec.len != 2'h1) begin
            d.state = S_B2;
          end else begin
            d.state = S_ISSUE;
          end
        end
      end
      S_B2: begin
        if (code_valid && !q.code_take) begin
          d.code_take = 1'b1;
          d.b2        = code_byte;
          d.pc        = q.pc + 16'h1;
          d.state     = (q.dec.len == 2'h3) ? S_B3 : S_ISSUE;
        end
      end
      S_B3: begin
        if (code_valid && !q.code_take) begin
          d.code_take = 1'b1;
          d.b3        = code_byte;
          d.pc        = q.pc + 16'h1;
          d.state     = S_ISSUE;
        end
      end
      S_ISSUE: begin
        d.rd_latch = 1'b0;
        unique case (q.dec.kind)
          K_JMP: begin
            d.pc    = {q.pc[15:11], q.op[7:5], q.b2};
            d.state = S_WAIT;
          end
          K_A_REG: begin
            d.rd_req  = 1'b1;
            d.rd_addr = {3'h0, bank_sel, q.op[2:0]};
            d.state   = S_RD;
          end
          K_A_IND: begin
            d.rd_req  = 1'b1;
            d.rd_addr = {3'h0, bank_sel, 2'h0, q.op[0]};
            d.state   = S_PTR;
          end
          K_A_IMM: begin
            d.opnd  = q.b2;
            d.state = S_EXEC;
          end
          default: begin
            d.rd_req   = 1'b1;
            d.rd_addr  = q.b2;
            d.rd_latch = dir_dest;
            d.state    = S_RD;
          end
        endcase
      end
      S_PTR: begin
        if (rd_valid) begin
          d.rd_req  = 1'b1;
          d.rd_addr = rd_data;
          d.state   = S_RD;
        end
      end
      S_RD: begin
        if (rd_valid) begin
          d.opnd  = rd_data;
          d.state = S_EXEC;
        end
      end
      S_EXEC: begin
        if (dir_dest) begin
          d.mask    = (q.dec.kind == K_D_IMM) ? q.b3 : acc_value;
          d.wr_en   = 1'b1;
          d.wr_addr = q.b2;
          d.wr_data = q.opnd & d.mask;
        end else begin
          d.mask   = acc_value;
          d.acc_we = 1'b1;
          d.acc_wd = acc_value & q.opnd;
        end
        d.state = S_WAIT;
      end
      S_WAIT: begin
        if (q.mc_cnt >= q.dec.cyc) begin
          d.done  = 1'b1;
          d.state = S_OP;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      q <= AJB_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign code_take       = q.code_take;
  assign program_counter = q.pc;
  assign rd_req          = q.rd_req;
  assign rd_addr         = q.rd_addr;
  assign rd_latch        = q.rd_latch;
  assign wr_en           = q.wr_en;
  assign wr_addr         = q.wr_addr;
  assign wr_data         = q.wr_data;
  assign acc_we          = q.acc_we;
  assign acc_wd          = q.acc_wd;
  assign instr_done      = q.done;
  assign bad_opcode      = q.bad;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_int_n);

  a_jump_target: assert property ((q.state == S_ISSUE && q.dec.kind == K_JMP) |=>
      q.pc == {$past(q.pc[15:11]), $past(q.op[7:5]), $past(q.b2)})
    else $error("page jump target wrong");
  a_jump_cycles: assert property ((instr_done && q.dec.kind == K_JMP) |->
      q.mc_cnt >= 2'h2 && q.dec.len == 2'h2)
    else $error("page jump length or cycles wrong");
  a_acc_result: assert property (acc_we |-> (acc_wd == (q.mask & q.opnd)) && !dir_dest)
    else $error("accumulator result wrong");
  a_dir_result: assert property (wr_en |-> (wr_data == (q.opnd & q.mask))
      && wr_addr == q.b2 && dir_dest)
    else $error("direct write result wrong");
  a_latch_read: assert property ((rd_req && q.state == S_RD) |-> rd_latch == dir_dest)
    else $error("port latch select wrong");
  a_reg_addr: assert property ((rd_req && q.dec.kind == K_A_REG) |->
      rd_addr == {3'h0, $past(bank_sel), q.op[2:0]})
    else $error("working register address wrong");
  a_ptr_addr: assert property ((q.state == S_PTR && rd_req) |->
      rd_addr[7:1] == {3'h0, $past(bank_sel), 2'h0} && rd_addr[0] == q.op[0])
    else $error("pointer register address wrong");
  a_imm_triple: assert property ((instr_done && q.dec.kind == K_D_IMM) |->
      q.dec.len == 2'h3 && q.mc_cnt >= 2'h2)
    else $error("three byte form wrong");
  a_single_byte: assert property ((q.state == S_ISSUE && q.dec.len == 2'h1) |->
      code_take && $past(q.state) == S_OP && q.pc == $past(q.pc) + 16'h1)
    else $error("one byte form took extra bytes");
  a_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("done held too long");

endmodule // ajb_exec

// ---- test/ajb_mem_model.sv ----
`timescale 1ns/1ns
module ajb_mem_model
  import ajb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic        slow,
  input  wire logic [15:0] program_counter,
  input  wire logic        code_take,
  output logic             code_valid,
  output logic [7:0]       code_byte,
  input  wire logic        rd_req,
  input  wire logic [7:0]  rd_addr,
  input  wire logic        rd_latch,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [7:0]  wr_data
);
  logic [7:0] code_mem [256];
  logic [7:0] data_mem [256];
  logic [7:0] junk_q = 8'h5A;
  logic [2:0] wait_q;
  logic [7:0] pin_v;

  // one byte every third cycle when taken, never while a take shows
  always @(posedge ref_clk) begin
    code_valid <= run & ~code_valid & ~code_take;
    junk_q <= ~junk_q;
  end
  // off-window lines show a toggling pattern
  assign code_byte = code_valid ? code_mem[program_counter[7:0]] : junk_q;
  // port pins read back inverted so a pin read is visible
  assign pin_v   = rd_addr[7] ? ~data_mem[rd_addr] : data_mem[rd_addr];
  assign rd_data = rd_valid ? (rd_latch ? data_mem[rd_addr] : pin_v) : junk_q;
  // reads answered two or five cycles after the request; writes land in the array
  always @(posedge ref_clk) begin
    rd_valid <= run && wait_q == 3'h1;
    if (!run) wait_q <= 3'h0;
    else if (rd_req) wait_q <= slow ? 3'h4 : 3'h1;
    else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
    if (wr_en) data_mem[wr_addr] <= wr_data;
  end
endmodule // ajb_mem_model

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb
  import ajb_pkg::*;
;
  logic        ref_clk, rst_n, run, slow, code_valid, code_take, rd_req, rd_latch;
  logic        rd_valid, wr_en, acc_we, instr_done, bad_opcode;
  logic [1:0]  bank_sel;
  logic [7:0]  acc_value, code_byte, rd_addr, rd_data, wr_addr, wr_data, acc_wd, got_v, got_a;
  logic [15:0] program_counter;
  int          n_fail = 0, total_checks = 0, n_acc = 0, n_wr = 0;
  logic [7:0]  prog [13];

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  ajb_exec u_dut (.ref_clk, .rst_n, .code_valid, .code_byte, .code_take, .program_counter,
    .bank_sel, .acc_value, .rd_req, .rd_addr, .rd_latch, .rd_valid, .rd_data, .wr_en,
    .wr_addr, .wr_data, .acc_we, .acc_wd, .instr_done, .bad_opcode);
  ajb_mem_model u_mem (.ref_clk, .run, .slow, .program_counter, .code_take, .code_valid,
    .code_byte, .rd_req, .rd_addr, .rd_latch, .rd_valid, .rd_data, .wr_en, .wr_addr, .wr_data);

  // capture accumulator and direct writes
  always @(posedge ref_clk) begin
    if (acc_we) begin
      n_acc <= n_acc + 1;
      got_v <= acc_wd;
    end
    if (wr_en) begin
      n_wr <= n_wr + 1;
      got_v <= wr_data;
      got_a <= wr_addr;
    end
  end

  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // kind 0 acc write, 1 direct write, 2 nothing, 3 unhandled opcode
  task automatic run_op(input string nm, input int kind, input logic [7:0] ev,
                        input logic [7:0] ea, input logic [15:0] epc, input int mc);
    int a0, w0, t, tw;
    a0 = n_acc;
    w0 = n_wr;
    t = 0;
    tw = 0;
    // opcode take first, then cycles up to the end pulse
    while (code_take !== 1'b1 && tw < 400) begin
      @(negedge ref_clk);
      tw++;
    end
    while ((kind == 3 ? bad_opcode : instr_done) !== 1'b1 && t < 400) begin
      @(negedge ref_clk);
      t++;
    end
    // judged at the falling edge, before the next opcode can move the counter
    chk(tw < 400 && t >= mc * MC_CLKS && t <= mc * MC_CLKS + 1, {nm, " timing"});
    chk(program_counter === epc, {nm, " pc"});
    chk((n_acc - a0) == (kind == 0) && (n_wr - w0) == (kind == 1), {nm, " dest"});
    if (kind == 1) chk(got_a === ea, {nm, " addr"});
    if (kind < 2) chk(got_v === ev, {nm, " value"});
    $display("test %s done", nm);
  endtask

  task automatic t_acc_forms;
    run_op("acc_reg", 0, 8'h41, 8'h00, 16'h0001, 1);
    // bank switch lands well before the indirect form issues
    @(posedge ref_clk) bank_sel <= 2'h2;
    run_op("acc_dir", 0, 8'h42, 8'h00, 16'h0003, 1);
    run_op("acc_ind", 0, 8'hC0, 8'h00, 16'h0004, 1);
    run_op("acc_imm", 0, 8'h03, 8'h00, 16'h0006, 1);
  endtask

  task automatic t_dir_forms;
    run_op("dir_acc", 1, 8'h82, 8'h90, 16'h0008, 1);
    @(posedge ref_clk) slow <= 1'b1;
    run_op("dir_imm", 1, 8'h02, 8'h90, 16'h000B, 2);
  endtask

  task automatic t_jump_bad;
    run_op("page_jump", 2, 8'h00, 8'h00, 16'h0523, 2);
    @(posedge ref_clk) slow <= 1'b0;
    run_op("acc_ind0", 0, 8'h42, 8'h00, 16'h0524, 1);
    run_op("unhandled", 3, 8'h00, 8'h00, 16'h0525, 0);
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog far beyond the expected few hundred cycles
  initial begin
    #(5000 * 100);
    n_fail++;
    test_done;
  end

  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    slow = 1'b0;
    bank_sel = 2'h1;
    acc_value = 8'hC3;
    prog = '{8'h5B, 8'h55, 8'h30, 8'h57, 8'h54, 8'h0F, 8'h52, 8'h90, 8'h53, 8'h90, 8'h73,
             8'hA1, 8'h23};
    foreach (prog[i]) u_mem.code_mem[i] = prog[i];
    u_mem.code_mem[8'h23] = 8'h56;
    u_mem.data_mem[8'h10] = 8'h30;
    u_mem.code_mem[8'h24] = 8'h00;
    u_mem.data_mem[8'h0B] = 8'h55;
    u_mem.data_mem[8'h30] = 8'h7E;
    u_mem.data_mem[8'h11] = 8'h40;
    u_mem.data_mem[8'h40] = 8'hF0;
    u_mem.data_mem[8'h90] = 8'hAA;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    run <= 1'b1;
    t_acc_forms;
    t_dir_forms;
    t_jump_bad;
    test_done;
  end
endmodule // tb
